/* src/sdc_top.sv */
// synthesizer divider registers, serial programming port and power-up sequencing
`timescale 1ns/1ps
module sdc_top #(
	parameter int unsigned SETTLE_CYCLES = sdc_pkg::XCO_SETTLE_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_sclk,
	input wire logic i_cs,
	input wire logic i_sdio,
	output logic o_sdio,
	output logic o_sdio_oe,
	input wire logic i_tx_active,
	input wire logic i_tx_data,
	input wire logic i_loop_locked,
	input wire logic i_pa_full_on,
	output logic [11:0] o_main_count,
	output logic [11:0] o_reference_divider,
	output logic [5:0] o_swallow_count,
	output logic [16:0] o_div_total,
	output logic o_prog_valid,
	output logic [4:0] o_crystal_trim,
	output logic [30:0] o_trim_cap_en,
	output logic [2:0] o_osc_bias_sel,
	output logic [1:0] o_osc_band_sel,
	output logic [1:0] o_prefilter_cutoff_sel,
	output logic o_signal_level_enable,
	output logic o_lock_detector_enable,
	output logic o_lock_indicator_pin,
	output logic o_xco_enable,
	output logic o_blocks_enable
);
	// -------------------------------------------------------------------
	// functions
	// -------------------------------------------------------------------
	function automatic logic [4:0] idx(input logic [6:0] a);
		return a[4:0];
	endfunction : idx

	function automatic logic [7:0] reg_mask(input logic [6:0] a);
		logic [7:0] m;
		unique case (a)
			sdc_pkg::ADDR_DETECT_FILTER: m = sdc_pkg::MASK_DETECT_FILTER;
			sdc_pkg::ADDR_OSC_BIAS_BAND: m = sdc_pkg::MASK_OSC_BIAS_BAND;
			sdc_pkg::ADDR_CRYSTAL_TRIM: m = sdc_pkg::MASK_CRYSTAL_TRIM;
			sdc_pkg::ADDR_SWALLOW_DIV0, sdc_pkg::ADDR_SWALLOW_DIV1: m = sdc_pkg::MASK_SWALLOW;
			sdc_pkg::ADDR_MAIN_DIV0_HIGH, sdc_pkg::ADDR_REF_DIV0_HIGH,
			sdc_pkg::ADDR_MAIN_DIV1_HIGH, sdc_pkg::ADDR_REF_DIV1_HIGH: m = sdc_pkg::MASK_DIV_HIGH;
			sdc_pkg::ADDR_MAIN_DIV0_LOW, sdc_pkg::ADDR_REF_DIV0_LOW,
			sdc_pkg::ADDR_MAIN_DIV1_LOW, sdc_pkg::ADDR_REF_DIV1_LOW: m = sdc_pkg::MASK_DIV_LOW;
			default: m = sdc_pkg::MASK_NONE;
		endcase
		return m;
	endfunction : reg_mask

	function automatic logic [7:0] reg_fixed(input logic [6:0] a);
		logic [7:0] f;
		unique case (a)
			sdc_pkg::ADDR_DETECT_FILTER: f = sdc_pkg::FIXED_DETECT_FILTER;
			sdc_pkg::ADDR_OSC_BIAS_BAND: f = sdc_pkg::FIXED_OSC_BIAS_BAND;
			sdc_pkg::ADDR_CRYSTAL_TRIM: f = sdc_pkg::FIXED_CRYSTAL_TRIM;
			default: f = sdc_pkg::FIXED_NONE;
		endcase
		return f;
	endfunction : reg_fixed

	function automatic logic [16:0] div_total(input logic [11:0] n, input logic [5:0] a);
		return ({5'h00, n} * sdc_pkg::PRESCALE_FACTOR) + {11'h000, a};
	endfunction : div_total

	function automatic logic [30:0] therm(input logic [4:0] t);
		logic [30:0] v;
		v = 31'h00000000;
		for (int k = 0; k < sdc_pkg::TRIM_CAPS; k++) begin
			v[k] = (5'(k) < t);
		end
		return v;
	endfunction : therm

	// -------------------------------------------------------------------
	// serial port, link clock domain
	// -------------------------------------------------------------------
	logic [7:0] act_mem [0:sdc_pkg::REG_COUNT-1];
	logic [7:0] pend_mem [0:sdc_pkg::REG_COUNT-1];
	logic [2:0] bit_cnt_reg;
	logic [2:0] out_cnt_reg;
	logic hdr_done_reg;
	logic rw_reg;
	logic [6:0] addr_reg;
	logic [7:0] in_sh_reg;
	logic [7:0] out_sh_reg;
	logic [14:0] wr_word_reg;
	logic wr_tgl_reg;

	// chip select low ends the access and clears the frame state
	wire ser_rst_b = i_rst_b & i_cs;
	wire byte_end = (bit_cnt_reg == sdc_pkg::BIT_LAST);
	wire rd_hit = (addr_reg <= sdc_pkg::ADDR_LAST);
	// registers only change after chip select low, so they stand still while read
	wire [7:0] rd_byte = rd_hit ?
		((act_mem[idx(addr_reg)] & reg_mask(addr_reg)) | reg_fixed(addr_reg)) : 8'h00;

	always_ff @(negedge i_sclk or negedge ser_rst_b) begin
		if (!ser_rst_b) begin
			bit_cnt_reg <= 3'h0;
			hdr_done_reg <= 1'b0;
			rw_reg <= 1'b0;
			addr_reg <= 7'h00;
			in_sh_reg <= 8'h00;
		end else begin
			in_sh_reg <= {in_sh_reg[6:0], i_sdio};
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (byte_end && !hdr_done_reg) begin
				addr_reg <= in_sh_reg[6:0];
				rw_reg <= i_sdio;
				hdr_done_reg <= 1'b1;
			end else if (byte_end) begin
				addr_reg <= addr_reg + 7'h01;
			end
		end
	end

	always_ff @(negedge i_sclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_word_reg <= 15'h0000;
			wr_tgl_reg <= 1'b0;
		end else if (byte_end && hdr_done_reg && !rw_reg && i_cs) begin
			wr_word_reg <= {addr_reg, in_sh_reg[6:0], i_sdio};
			wr_tgl_reg <= ~wr_tgl_reg;
		end
	end

	always_ff @(posedge i_sclk or negedge ser_rst_b) begin
		if (!ser_rst_b) begin
			out_cnt_reg <= 3'h0;
			out_sh_reg <= 8'h00;
			o_sdio <= 1'b0;
			o_sdio_oe <= 1'b0;
		end else if (hdr_done_reg && rw_reg) begin
			o_sdio_oe <= 1'b1;
			out_cnt_reg <= out_cnt_reg + 3'h1;
			if (out_cnt_reg == 3'h0) begin
				o_sdio <= rd_byte[7];
				out_sh_reg <= {rd_byte[6:0], 1'b0};
			end else begin
				o_sdio <= out_sh_reg[7];
				out_sh_reg <= {out_sh_reg[6:0], 1'b0};
			end
		end
	end

	// -------------------------------------------------------------------
	// crossing into the system clock domain
	// -------------------------------------------------------------------
	logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic lock_s1_reg, lock_s2_reg, pa_s1_reg, pa_s2_reg;
	logic commit_reg;
	logic [19:0] pend_v_reg;

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{tgl_s1_reg, tgl_s2_reg, tgl_s3_reg} <= 3'h0;
			{cs_s1_reg, cs_s2_reg, cs_s3_reg} <= 3'h0;
			{lock_s1_reg, lock_s2_reg, pa_s1_reg, pa_s2_reg} <= 4'h0;
		end else begin
			{tgl_s1_reg, tgl_s2_reg, tgl_s3_reg} <= {wr_tgl_reg, tgl_s1_reg, tgl_s2_reg};
			{cs_s1_reg, cs_s2_reg, cs_s3_reg} <= {i_cs, cs_s1_reg, cs_s2_reg};
			{lock_s1_reg, lock_s2_reg} <= {i_loop_locked, lock_s1_reg};
			{pa_s1_reg, pa_s2_reg} <= {i_pa_full_on, pa_s1_reg};
		end
	end

	wire wr_evt = tgl_s2_reg ^ tgl_s3_reg;
	wire cs_fall = cs_s3_reg & ~cs_s2_reg;
	wire [6:0] wr_addr = wr_word_reg[14:8];
	wire wr_hit = wr_evt && (wr_addr <= sdc_pkg::ADDR_LAST);
	wire [19:0] wr_onehot = wr_hit ? (20'h00001 << idx(wr_addr)) : 20'h00000;
	wire [19:0] pend_v_next = (commit_reg ? 20'h00000 : pend_v_reg) | wr_onehot;

	// -------------------------------------------------------------------
	// staged and active register storage
	// -------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			commit_reg <= 1'b0;
			pend_v_reg <= 20'h00000;
			for (int i = 0; i < sdc_pkg::REG_COUNT; i++) begin
				pend_mem[i] <= sdc_pkg::RESET_BYTE;
				act_mem[i] <= sdc_pkg::RESET_BYTE;
			end
			act_mem[idx(sdc_pkg::ADDR_CRYSTAL_TRIM)] <= sdc_pkg::RESET_CRYSTAL_TRIM;
		end else begin
			// one cycle late so a last byte landing with chip select still gets in
			commit_reg <= cs_fall;
			pend_v_reg <= pend_v_next;
			for (int i = 0; i < sdc_pkg::REG_COUNT; i++) begin
				if (commit_reg && pend_v_reg[i]) begin
					act_mem[i] <= pend_mem[i];
				end
			end
			if (wr_hit) begin
				pend_mem[idx(wr_addr)] <= wr_word_reg[7:0] & reg_mask(wr_addr);
			end
		end
	end

	// -------------------------------------------------------------------
	// field decode
	// -------------------------------------------------------------------
	wire [11:0] main0 = {act_mem[idx(sdc_pkg::ADDR_MAIN_DIV0_HIGH)][3:0],
		act_mem[idx(sdc_pkg::ADDR_MAIN_DIV0_LOW)]};
	wire [11:0] ref0 = {act_mem[idx(sdc_pkg::ADDR_REF_DIV0_HIGH)][3:0],
		act_mem[idx(sdc_pkg::ADDR_REF_DIV0_LOW)]};
	wire [5:0] swal0 = act_mem[idx(sdc_pkg::ADDR_SWALLOW_DIV0)][5:0];
	wire [11:0] main1 = {act_mem[idx(sdc_pkg::ADDR_MAIN_DIV1_HIGH)][3:0],
		act_mem[idx(sdc_pkg::ADDR_MAIN_DIV1_LOW)]};
	wire [11:0] ref1 = {act_mem[idx(sdc_pkg::ADDR_REF_DIV1_HIGH)][3:0],
		act_mem[idx(sdc_pkg::ADDR_REF_DIV1_LOW)]};
	wire [5:0] swal1 = act_mem[idx(sdc_pkg::ADDR_SWALLOW_DIV1)][5:0];
	wire [7:0] det_byte = act_mem[idx(sdc_pkg::ADDR_DETECT_FILTER)];
	wire [7:0] osc_byte = act_mem[idx(sdc_pkg::ADDR_OSC_BIAS_BAND)];
	wire [4:0] trim = act_mem[idx(sdc_pkg::ADDR_CRYSTAL_TRIM)][4:0];
	wire lock_en = det_byte[sdc_pkg::LOCK_EN_BIT];
	// set 1 only for a transmitted one; receive and transmitted zeros use set 0
	wire use_set1 = i_tx_active & i_tx_data;
	wire [11:0] main_sel = use_set1 ? main1 : main0;
	wire [11:0] ref_sel = use_set1 ? ref1 : ref0;
	wire [5:0] swal_sel = use_set1 ? swal1 : swal0;
	wire prog_ok = (swal_sel != 6'h00) && ({6'h00, swal_sel} < main_sel);
	// during transmit, lock is withheld until the amplifier is fully on
	wire lock_next = lock_en & lock_s2_reg & (~i_tx_active | pa_s2_reg);

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_main_count <= 12'h000;
			o_reference_divider <= 12'h000;
			o_swallow_count <= 6'h00;
			o_div_total <= 17'h00000;
			o_prog_valid <= 1'b0;
			o_crystal_trim <= 5'h00;
			o_trim_cap_en <= 31'h00000000;
			o_osc_bias_sel <= 3'h0;
			o_osc_band_sel <= 2'h0;
			o_prefilter_cutoff_sel <= 2'h0;
			o_signal_level_enable <= 1'b0;
			o_lock_detector_enable <= 1'b0;
			o_lock_indicator_pin <= 1'b0;
		end else begin
			o_main_count <= main_sel;
			o_reference_divider <= ref_sel;
			o_swallow_count <= swal_sel;
			o_div_total <= div_total(main_sel, swal_sel);
			o_prog_valid <= prog_ok;
			o_crystal_trim <= trim;
			o_trim_cap_en <= therm(trim);
			o_osc_bias_sel <= osc_byte[sdc_pkg::OSC_BIAS_LSB +: 3];
			o_osc_band_sel <= osc_byte[sdc_pkg::OSC_BAND_LSB +: 2];
			o_prefilter_cutoff_sel <= det_byte[sdc_pkg::PREFILTER_LSB +: 2];
			o_signal_level_enable <= det_byte[sdc_pkg::SIGNAL_LEVEL_BIT];
			o_lock_detector_enable <= lock_en;
			o_lock_indicator_pin <= lock_next;
		end
	end

	// -------------------------------------------------------------------
	// power-up sequencing
	// -------------------------------------------------------------------
	sdc_pkg::sdc_pwr_t pwr_reg, pwr_next;
	logic [19:0] settle_cnt_reg;
	wire settle_done = (settle_cnt_reg == 20'(SETTLE_CYCLES - 1));

	always_comb begin
		pwr_next = pwr_reg;
		unique case (pwr_reg)
			sdc_pkg::PWR_XCO_ONLY: if (settle_done) pwr_next = sdc_pkg::PWR_ALL_ON;
			sdc_pkg::PWR_ALL_ON: pwr_next = sdc_pkg::PWR_ALL_ON;
			default: pwr_next = sdc_pkg::PWR_XCO_ONLY;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_reg <= sdc_pkg::PWR_XCO_ONLY;
			settle_cnt_reg <= 20'h00000;
			o_xco_enable <= 1'b1;
			o_blocks_enable <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			o_xco_enable <= 1'b1;
			o_blocks_enable <= (pwr_next == sdc_pkg::PWR_ALL_ON);
			if (pwr_reg == sdc_pkg::PWR_XCO_ONLY) begin
				settle_cnt_reg <= settle_cnt_reg + 20'h00001;
			end
		end
	end

	// -------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	AST_LOCK_LOW_DISABLED: assert property ((!lock_en) [*2] |-> !o_lock_indicator_pin)
		else $error("lock output high with detector disabled");
	AST_LOCK_FOLLOWS_LOOP: assert property (
		(lock_en && lock_s2_reg && !i_tx_active) |=> o_lock_indicator_pin)
		else $error("lock output low while locked and enabled");
	AST_LOCK_WAITS_PA: assert property ((i_tx_active && !pa_s2_reg) |=> !o_lock_indicator_pin)
		else $error("lock shown before amplifier fully on");
	AST_TX_ONE_SET1: assert property (
		(i_tx_active && i_tx_data) |=> (o_main_count == $past(main1)
		&& o_reference_divider == $past(ref1) && o_swallow_count == $past(swal1)))
		else $error("transmit one did not use set 1");
	AST_RX_SET0: assert property (
		(!i_tx_active) |=> (o_main_count == $past(main0) && o_swallow_count == $past(swal0)))
		else $error("receive did not use set 0");
	AST_TOTAL_RATIO: assert property (
		o_div_total == div_total(o_main_count, o_swallow_count))
		else $error("divide total mismatch");
	AST_TRIM_CAPS: assert property ($countones(o_trim_cap_en) == int'(o_crystal_trim))
		else $error("trim capacitor count mismatch");
	AST_HOLD_UNTIL_CS: assert property (!commit_reg |=> ($stable(main0) && $stable(trim)))
		else $error("register changed without chip select low");
	AST_BLOCKS_WAIT: assert property (
		(pwr_reg == sdc_pkg::PWR_XCO_ONLY && !settle_done) |=> !o_blocks_enable)
		else $error("blocks powered before oscillator settled");

	COV_COMMIT: cover property (commit_reg && pend_v_reg != 20'h00000);
	COV_TX_SET1: cover property (i_tx_active && i_tx_data ##1 i_tx_active && !i_tx_data);
	COV_LOCK: cover property ($rose(o_lock_indicator_pin));
	COV_POWER_ON: cover property ($rose(o_blocks_enable));
endmodule : sdc_top

/* inc/sdc_pkg.sv */
// constants shared by the synthesizer divider configuration block
package sdc_pkg;
	// -------------------------------------------------------------------
	// register addresses (7-bit serial address space)
	// -------------------------------------------------------------------
	localparam logic [6:0] ADDR_DETECT_FILTER = 7'h01;
	localparam logic [6:0] ADDR_OSC_BIAS_BAND = 7'h03;
	localparam logic [6:0] ADDR_CRYSTAL_TRIM = 7'h09;
	localparam logic [6:0] ADDR_SWALLOW_DIV0 = 7'h0A;
	localparam logic [6:0] ADDR_MAIN_DIV0_HIGH = 7'h0B;
	localparam logic [6:0] ADDR_MAIN_DIV0_LOW = 7'h0C;
	localparam logic [6:0] ADDR_REF_DIV0_HIGH = 7'h0D;
	localparam logic [6:0] ADDR_REF_DIV0_LOW = 7'h0E;
	localparam logic [6:0] ADDR_SWALLOW_DIV1 = 7'h0F;
	localparam logic [6:0] ADDR_MAIN_DIV1_HIGH = 7'h10;
	localparam logic [6:0] ADDR_MAIN_DIV1_LOW = 7'h11;
	localparam logic [6:0] ADDR_REF_DIV1_HIGH = 7'h12;
	localparam logic [6:0] ADDR_REF_DIV1_LOW = 7'h13;
	localparam logic [6:0] ADDR_LAST = 7'h13;
	localparam int REG_COUNT = 20;
	// -------------------------------------------------------------------
	// writable masks and fixed read-back bits
	// -------------------------------------------------------------------
	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] MASK_DETECT_FILTER = 8'h0F;
	localparam logic [7:0] MASK_OSC_BIAS_BAND = 8'h1F;
	localparam logic [7:0] MASK_CRYSTAL_TRIM = 8'h1F;
	localparam logic [7:0] MASK_SWALLOW = 8'h3F;
	localparam logic [7:0] MASK_DIV_HIGH = 8'h0F;
	localparam logic [7:0] MASK_DIV_LOW = 8'hFF;
	localparam logic [7:0] FIXED_DETECT_FILTER = 8'h80;
	localparam logic [7:0] FIXED_OSC_BIAS_BAND = 8'hC0;
	localparam logic [7:0] FIXED_CRYSTAL_TRIM = 8'h60;
	localparam logic [7:0] FIXED_NONE = 8'h00;
	// -------------------------------------------------------------------
	// field positions and reset values
	// -------------------------------------------------------------------
	localparam int PREFILTER_LSB = 0;
	localparam int LOCK_EN_BIT = 2;
	localparam int SIGNAL_LEVEL_BIT = 3;
	localparam int OSC_BAND_LSB = 0;
	localparam int OSC_BIAS_LSB = 2;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] RESET_CRYSTAL_TRIM = 8'h0D;
	// -------------------------------------------------------------------
	// divider arithmetic
	// -------------------------------------------------------------------
	localparam logic [16:0] PRESCALE_FACTOR = 17'h0001F;
	localparam int TRIM_CAPS = 31;
	// -------------------------------------------------------------------
	// timing
	// -------------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int XCO_SETTLE_US = 750;
	localparam int XCO_SETTLE_CYCLES = XCO_SETTLE_US * CLK_MHZ;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// -------------------------------------------------------------------
	// power-up sequence states
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_XCO_ONLY = 2'b00,
		PWR_ALL_ON = 2'b01
	} sdc_pwr_t;
endpackage : sdc_pkg

/* bench/sdc_host_model.sv */
// host model driving the three-wire programming port
`timescale 1ns/1ps
module sdc_host_model (
	output logic o_sclk,
	output logic o_cs,
	output logic o_sdio,
	input wire logic i_sdio_wire
);
	logic [7:0] rd_byte;
	int rd_cnt;
	initial begin
		o_sclk = 1'b0;
		o_cs = 1'b0;
		o_sdio = 1'b0;
		rd_byte = 8'h00;
		rd_cnt = 0;
	end
	// one access with chip select left high; done() closes it
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] wd[$], input int n);
		logic [7:0] cur;
		#3 o_cs <= 1'b1;
		#15;
		for (int j = 0; j <= n; j++) begin
			cur = (j == 0) ? {a, rd} : (rd ? 8'h00 : wd[j-1]);
			for (int k = 7; k >= 0; k--) begin
				o_sclk <= 1'b1;
				#2;
				// a released line carries a changing pattern, not the last bit
				o_sdio <= (j == 0 || !rd) ? cur[k] : ~o_sdio;
				#13;
				o_sclk <= 1'b0;
				if (j > 0 && rd) rd_byte = {rd_byte[6:0], i_sdio_wire};
				#15;
			end
			if (j > 0 && rd) rd_cnt++;
		end
	endtask : xfer
	// chip select low loads the written values
	task automatic done();
		#15 o_cs <= 1'b0;
		o_sdio <= 1'b0;
		#75;
	endtask : done
endmodule : sdc_host_model

/* bench/sdc_top_tb_top.sv */
// self-checking bench of the divider configuration block
`timescale 1ns/1ps
module sdc_top_tb_top;
	typedef struct {string what; int sel; logic [31:0] exp;} sdc_note_t;
	logic i_mclk, i_rst_b, tx_a, tx_d, lk, pa, sclk, cs, host_sdio, dev_sdio, dev_oe, sdio_wire;
	logic [11:0] main_c, ref_d;
	logic [5:0] sw;
	logic [16:0] tot;
	logic [4:0] trim;
	logic [30:0] caps;
	logic [2:0] bias;
	logic [1:0] band, pf;
	logic pv, sig, len, lock, xco, blk;
	logic [31:0] rnd = 32'h0000C9A3;
	sdc_note_t notes[$];
	int look_cnt = 0, fails = 0, compares = 0, cyc = 0;
	assign sdio_wire = dev_oe ? dev_sdio : host_sdio;
	sdc_host_model host (.o_sclk(sclk), .o_cs(cs), .o_sdio(host_sdio), .i_sdio_wire(sdio_wire));
	sdc_top #(.SETTLE_CYCLES(20)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sclk(sclk),
		.i_cs(cs), .i_sdio(sdio_wire), .o_sdio(dev_sdio), .o_sdio_oe(dev_oe),
		.i_tx_active(tx_a), .i_tx_data(tx_d), .i_loop_locked(lk), .i_pa_full_on(pa),
		.o_main_count(main_c), .o_reference_divider(ref_d), .o_swallow_count(sw),
		.o_div_total(tot), .o_prog_valid(pv), .o_crystal_trim(trim), .o_trim_cap_en(caps),
		.o_osc_bias_sel(bias), .o_osc_band_sel(band), .o_prefilter_cutoff_sel(pf),
		.o_signal_level_enable(sig), .o_lock_detector_enable(len),
		.o_lock_indicator_pin(lock), .o_xco_enable(xco), .o_blocks_enable(blk));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// -------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------
	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction : xs
	function automatic logic [7:0] rback(input logic [6:0] a, input logic [7:0] d);
		case (a)
			7'h01: return (d & sdc_pkg::MASK_DETECT_FILTER) | sdc_pkg::FIXED_DETECT_FILTER;
			7'h03: return (d & sdc_pkg::MASK_OSC_BIAS_BAND) | sdc_pkg::FIXED_OSC_BIAS_BAND;
			7'h09: return (d & sdc_pkg::MASK_CRYSTAL_TRIM) | sdc_pkg::FIXED_CRYSTAL_TRIM;
			7'h0A, 7'h0F: return d & sdc_pkg::MASK_SWALLOW;
			7'h0B, 7'h0D, 7'h10, 7'h12: return d & sdc_pkg::MASK_DIV_HIGH;
			7'h0C, 7'h0E, 7'h11, 7'h13: return d;
			default: return sdc_pkg::MASK_NONE;
		endcase
	endfunction : rback
	function automatic logic [31:0] obs(input int sel);
		case (sel)
			1: return {20'h00000, main_c};
			2: return {20'h00000, ref_d};
			3: return {26'h0000000, sw};
			4: return {15'h0000, tot};
			5: return {31'h00000000, pv};
			6: return {27'h0000000, trim};
			7: return {1'h0, caps};
			8: return {27'h0000000, bias, band};
			9: return {31'h00000000, lock};
			10: return {30'h00000000, xco, blk};
			12: return {31'h00000000, dev_oe};
			default: return {28'h0000000, sig, len, pf};
		endcase
	endfunction : obs
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic look(input string what, input int sel, input logic [31:0] exp);
		#1 notes.push_back('{what, sel, exp});
		look_cnt++;
	endtask : look
	task automatic setin(input logic a, input logic d, input logic l, input logic p);
		@(posedge i_mclk);
		tx_a <= a;
		tx_d <= d;
		lk <= l;
		pa <= p;
	endtask : setin
	task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
		host.xfer(a, 1'b0, d, d.size());
		host.done();
		repeat (8) @(posedge i_mclk);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] e[$]);
		foreach (e[i]) notes.push_back('{"read byte", 0, {24'h000000, e[i]}});
		host.xfer(a, 1'b1, e, e.size());
		look("read drive enable", 12, 32'h1);
		host.done();
		look("read drive enable", 12, 32'h0);
	endtask : rd
	task automatic setchk(input logic a, input logic d, input logic [11:0] m,
		input logic [11:0] r, input logic [5:0] s);
		setin(a, d, lk, pa);
		repeat (3) @(posedge i_mclk);
		look("main count", 1, {20'h00000, m});
		look("reference divider", 2, {20'h00000, r});
		look("swallow count", 3, {26'h0000000, s});
		look("divide total", 4, 31 * m + s);
		look("program valid", 5, {31'h00000000, (s >= 6'h01) && (s < m)});
	endtask : setchk
	task automatic stop_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	// -------------------------------------------------------------------
	// result monitor and hang guard
	// -------------------------------------------------------------------
	initial begin
		sdc_note_t n;
		forever begin
			@(look_cnt or host.rd_cnt);
			n = notes.pop_front();
			check(n.what, (n.sel == 0) ? {24'h000000, host.rd_byte} : obs(n.sel), n.exp);
		end
	end
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	// -------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------
	initial begin
		logic [7:0] wb[$];
		logic [7:0] eb[$];
		logic [11:0] m0, r0, m1, r1;
		logic [4:0] t;
		logic a, l, p, en;
		{i_rst_b, tx_a, tx_d, lk, pa} = 5'h00;
		repeat (4) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
		look("power enables", 10, 32'h2);
		look("crystal trim", 6, 32'hD);
		look("trim caps", 7, 32'h1FFF);
		// no programming until the oscillator has settled
		for (int i = 0; i < 100 && blk !== 1'b1; i++) @(posedge i_mclk);
		look("power enables", 10, 32'h3);
		rd(7'h01, '{8'h80});
		rd(7'h03, '{8'hC0});
		rd(7'h09, '{8'h6D});
		for (int i = 0; i < 10; i++) wb.push_back(8'(xs()));
		host.xfer(7'h0A, 1'b0, wb, 10);
		repeat (10) @(posedge i_mclk);
		look("main count", 1, 32'h0);
		host.done();
		repeat (8) @(posedge i_mclk);
		m0 = {wb[1][3:0], wb[2]};
		r0 = {wb[3][3:0], wb[4]};
		m1 = {wb[6][3:0], wb[7]};
		r1 = {wb[8][3:0], wb[9]};
		setchk(1'b0, 1'b0, m0, r0, wb[0][5:0]);
		setchk(1'b1, 1'b1, m1, r1, wb[5][5:0]);
		setchk(1'b1, 1'b0, m0, r0, wb[0][5:0]);
		setchk(1'b0, 1'b1, m0, r0, wb[0][5:0]);
		foreach (wb[i]) eb.push_back(rback(7'(7'h0A + i), wb[i]));
		rd(7'h0A, eb);
		wr(7'h03, '{8'hED});
		look("bias and band", 8, 32'h0D);
		rd(7'h03, '{8'hCD});
		for (int i = 0; i < 4; i++) begin
			t = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'(xs());
			wr(7'h09, '{{3'h5, t}});
			look("crystal trim", 6, {27'h0000000, t});
			look("trim caps", 7, (32'h1 << t) - 32'h1);
			rd(7'h09, '{{3'h3, t}});
		end
		// detect control is written first, then transmit, lock and amplifier inputs are set together
		for (int i = 0; i < 10; i++) begin
			en = (i < 6);
			wr(7'h01, '{en ? 8'hF4 : 8'h0B});
			look("detect control", 11, en ? 32'h4 : 32'hB);
			{a, l, p} = (i == 0 || i == 6) ? 3'h2 : 3'(xs());
			setin(a, 1'(xs()), l, p); // host never acts on lock while transmitting
			repeat (6) @(posedge i_mclk);
			look("lock indicator", 9, {31'h0, en & l & (!a | p)});
		end
		wr(7'h05, '{8'hFF});
		rd(7'h05, '{8'h00});
		rd(7'h14, '{8'h00});
		repeat (4) @(posedge i_mclk);
		stop_test();
	end
endmodule : sdc_top_tb_top
